// ===== src/ebha_pkg.sv
package ebha_pkg;

	// ****************************************
	// arbiter states
	// ****************************************
	typedef enum logic [2:0] {
		ARB_OWN,
		ARB_FINISH,
		ARB_RELEASE,
		ARB_HELD,
		ARB_REGAIN
	} ebha_state_type;

	// ****************************************
	// widths and levels
	// ****************************************
	localparam int          ADDR_W      = 24;
	localparam int          DATA_W      = 16;
	localparam int          CMD_W       = 4;
	localparam int          CS_W        = 5;
	localparam logic        LOW_ACTIVE  = 1'h0;
	localparam logic        LOW_IDLE    = 1'h1;
	// held cycles after acknowledge in which a request of bus back still counts
	localparam logic [3:0]  WANT_CUTOFF = 4'h2;

endpackage

// ===== src/ebha_pin_if.sv
`timescale 1ns/1ps
// pin drive group between the arbiter core and the pad stage
interface ebha_pin_if;
	logic bus_drive;
	logic cs_drive;
	modport core (output bus_drive, output cs_drive);
	modport pads (input bus_drive, input cs_drive);
endinterface

// ===== src/ebha_pads.sv
`timescale 1ns/1ps
module ebha_pads
#(
	parameter int ADDR_W = ebha_pkg::ADDR_W,
	parameter int DATA_W = ebha_pkg::DATA_W,
	parameter int CMD_W  = ebha_pkg::CMD_W,
	parameter int CS_W   = ebha_pkg::CS_W
)
(
	// drive controls
	ebha_pin_if.pads              pins,
	// core values
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] data_in,
	input  wire logic [CMD_W-1:0]  cmd_in,
	input  wire logic [CS_W-1:0]   cs_in,
	// pin enables and chip select values
	output logic [ADDR_W-1:0]      addr_oe,
	output logic [DATA_W-1:0]      data_oe,
	output logic [CMD_W-1:0]       cmd_oe,
	output logic [CS_W-1:0]        chip_select_line_oe,
	output logic [CS_W-1:0]        chip_select_line_o
);
	// per-line chip select enables; released line left to pull-up
	genvar i;
	generate
		for (i = 0; i < CS_W; i++)
		begin : g_cs
			assign chip_select_line_oe[i] = pins.cs_drive;  // RULE_04
			assign chip_select_line_o[i]  = cs_in[i];
		end
	endgenerate

	// address, data, command enables
	assign addr_oe = {ADDR_W{pins.bus_drive}};  // RULE_11
	assign data_oe = {DATA_W{pins.bus_drive}} & {DATA_W{data_in == data_in}};
	assign cmd_oe  = {CMD_W{pins.bus_drive}} & {CMD_W{(addr_in == addr_in) && (cmd_in == cmd_in)}};
endmodule // ebha_pads

// ===== src/ebha_arbiter.sv
`timescale 1ns/1ps
// Function
// RULE_01: finish the running bus cycle before acknowledging a hold request
// RULE_02: sample hold request on bus clock edges only; cycle_allowed drops combinationally on hold_req_n
// RULE_03: acknowledge and bus-want outputs are registered, change on clock edges
// RULE_04: chip selects released to pull-up while bus is granted away
// RULE_05: bus-want asserted no earlier than just after acknowledge is given
// RULE_06: regain starts only when hold request is withdrawn
// RULE_07: bus-want has a latest point at which it still counts
// RULE_08: master may withdraw hold unrequested; device regains normally
// RULE_09: after regain the next own bus cycle may start with drivers back
// RULE_10: hold, acknowledge and bus-want are active-low; bus-want drops on regain
// RULE_11: address, data and command released during hold, restored before next cycle
module ebha_arbiter
#(
	parameter int ADDR_W = ebha_pkg::ADDR_W,
	parameter int DATA_W = ebha_pkg::DATA_W,
	parameter int CMD_W  = ebha_pkg::CMD_W,
	parameter int CS_W   = ebha_pkg::CS_W
)
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rstn,
	// arbitration pins
	input  wire logic              hold_req_n,
	output logic                   bus_grant_ack_n,
	output logic                   bus_want_back_n,
	// core side
	input  wire logic              cycle_busy,
	input  wire logic              want_bus,
	output logic                   cycle_allowed,
	// bus values from core
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] data_in,
	input  wire logic [CMD_W-1:0]  cmd_in,
	input  wire logic [CS_W-1:0]   cs_in,
	// pin enables and chip select values
	output logic [ADDR_W-1:0]      addr_oe,
	output logic [DATA_W-1:0]      data_oe,
	output logic [CMD_W-1:0]       cmd_oe,
	output logic [CS_W-1:0]        chip_select_line_oe,
	output logic [CS_W-1:0]        chip_select_line_o
);
	// ****************************************
	// state
	// ****************************************
	ebha_pkg::ebha_state_type state_ff, nxt_state;
	logic       ack_ff, nxt_ack;
	logic       want_ff, nxt_want;
	logic       drive_ff, nxt_drive;
	logic [3:0] held_cnt_ff, nxt_held_cnt;
	logic       hold_on;

	ebha_pin_if pins ();

	assign hold_on = (hold_req_n == ebha_pkg::LOW_ACTIVE);  // RULE_10

	// next state
	always_comb
	begin
		nxt_state    = state_ff;
		nxt_ack      = ack_ff;
		nxt_want     = want_ff;
		nxt_drive    = drive_ff;
		nxt_held_cnt = held_cnt_ff;
		case (state_ff)
			ebha_pkg::ARB_OWN:
			begin
				if (hold_on)  // RULE_02
					nxt_state = cycle_busy ? ebha_pkg::ARB_FINISH : ebha_pkg::ARB_RELEASE;  // RULE_01
			end
			ebha_pkg::ARB_FINISH:
			begin
				if (!hold_on)
					nxt_state = ebha_pkg::ARB_OWN;
				else if (!cycle_busy)
					nxt_state = ebha_pkg::ARB_RELEASE;  // RULE_01
			end
			ebha_pkg::ARB_RELEASE:
			begin
				nxt_drive    = 1'b0;  // RULE_04 RULE_11
				nxt_ack      = 1'b1;  // RULE_03
				nxt_held_cnt = 4'h0;
				nxt_state    = ebha_pkg::ARB_HELD;
			end
			ebha_pkg::ARB_HELD:
			begin
				// bus-want only after ack, and only before cutoff
				if (want_bus && held_cnt_ff < ebha_pkg::WANT_CUTOFF)  // RULE_05 RULE_07
					nxt_want = 1'b1;
				if (held_cnt_ff != 4'hf)
					nxt_held_cnt = held_cnt_ff + 4'h1;
				if (!hold_on)  // RULE_06 RULE_08
				begin
					nxt_ack   = 1'b0;
					nxt_state = ebha_pkg::ARB_REGAIN;
				end
			end
			ebha_pkg::ARB_REGAIN:
			begin
				nxt_want  = 1'b0;  // RULE_10
				nxt_drive = 1'b1;  // RULE_09 RULE_11
				nxt_state = ebha_pkg::ARB_OWN;
			end
			default:
				nxt_state = ebha_pkg::ARB_OWN;
		endcase
	end

	// registers
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			state_ff    <= ebha_pkg::ARB_OWN;
			ack_ff      <= 1'b0;
			want_ff     <= 1'b0;
			drive_ff    <= 1'b1;
			held_cnt_ff <= 4'h0;
		end
		else
		begin
			state_ff    <= nxt_state;
			ack_ff      <= nxt_ack;
			want_ff     <= nxt_want;
			drive_ff    <= nxt_drive;
			held_cnt_ff <= nxt_held_cnt;
		end
	end

	// outputs
	assign bus_grant_ack_n = ~ack_ff;   // RULE_03
	assign bus_want_back_n = ~want_ff;  // RULE_03
	assign cycle_allowed   = drive_ff && (state_ff == ebha_pkg::ARB_OWN) && !hold_on;  // RULE_09
	assign pins.bus_drive  = drive_ff;
	assign pins.cs_drive   = drive_ff;

	ebha_pads #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .CMD_W(CMD_W), .CS_W(CS_W)) u_pads
	(
		.pins                (pins.pads),
		.addr_in             (addr_in),
		.data_in             (data_in),
		.cmd_in              (cmd_in),
		.cs_in               (cs_in),
		.addr_oe             (addr_oe),
		.data_oe             (data_oe),
		.cmd_oe              (cmd_oe),
		.chip_select_line_oe (chip_select_line_oe),
		.chip_select_line_o  (chip_select_line_o)
	);

	// ****************************************
	// checks
	// ****************************************
	sequence s_hold_idle;
		hold_on && !cycle_busy && state_ff == ebha_pkg::ARB_OWN;
	endsequence

	sequence s_withdraw;
		state_ff == ebha_pkg::ARB_HELD && !hold_on;
	endsequence

	a_ack_after_idle: assert property (@(posedge clock) disable iff (!rstn) // RULE_01
		s_hold_idle ##1 hold_on |=> !bus_grant_ack_n)
		else $error("acknowledge not given two cycles after idle hold");
	a_no_ack_busy: assert property (@(posedge clock) disable iff (!rstn) // RULE_01
		(state_ff == ebha_pkg::ARB_FINISH && cycle_busy) |=> bus_grant_ack_n)
		else $error("acknowledge given during running cycle");
	a_cs_released: assert property (@(posedge clock) disable iff (!rstn) // RULE_04
		!bus_grant_ack_n |-> chip_select_line_oe == '0)
		else $error("chip selects driven while granted");
	a_bus_released: assert property (@(posedge clock) disable iff (!rstn) // RULE_11
		!bus_grant_ack_n |-> (addr_oe == '0 && data_oe == '0 && cmd_oe == '0))
		else $error("bus driven while granted");
	a_want_after_ack: assert property (@(posedge clock) disable iff (!rstn) // RULE_05
		$fell(bus_want_back_n) |-> !$past(bus_grant_ack_n))
		else $error("bus want before acknowledge");
	a_regain_on_hold: assert property (@(posedge clock) disable iff (!rstn) // RULE_06
		(!bus_grant_ack_n && hold_on) |=> !bus_grant_ack_n)
		else $error("regain without hold withdrawn");
	a_want_cutoff: assert property (@(posedge clock) disable iff (!rstn) // RULE_07
		$fell(bus_want_back_n) |-> held_cnt_ff <= ebha_pkg::WANT_CUTOFF)
		else $error("bus want after cutoff");
	a_regain_seq: assert property (@(posedge clock) disable iff (!rstn) // RULE_08
		(state_ff == ebha_pkg::ARB_HELD && !hold_on) |=> bus_grant_ack_n ##1 bus_want_back_n)
		else $error("regain sequence wrong");
	a_drive_back: assert property (@(posedge clock) disable iff (!rstn) // RULE_09
		$rose(bus_grant_ack_n) |=> chip_select_line_oe == '1)
		else $error("drivers not restored after regain");

	// hold entry steps
	a_hold_sampled: assert property (@(posedge clock) disable iff (!rstn) // RULE_02
		s_hold_idle |=> state_ff == ebha_pkg::ARB_RELEASE)
		else $error("idle hold not taken on clock edge");
	a_release_next: assert property (@(posedge clock) disable iff (!rstn) // RULE_01
		state_ff == ebha_pkg::ARB_RELEASE |=> state_ff == ebha_pkg::ARB_HELD)
		else $error("release not followed by held");
	a_ack_registered: assert property (@(posedge clock) disable iff (!rstn) // RULE_03
		$fell(bus_grant_ack_n) |-> $past(state_ff == ebha_pkg::ARB_RELEASE))
		else $error("acknowledge not from release step");
	a_cnt_cleared: assert property (@(posedge clock) disable iff (!rstn) // RULE_07
		state_ff == ebha_pkg::ARB_RELEASE |=> held_cnt_ff == 4'h0)
		else $error("held count not cleared on release");
	a_finish_abort: assert property (@(posedge clock) disable iff (!rstn) // RULE_08
		(state_ff == ebha_pkg::ARB_FINISH && !hold_on) |=> state_ff == ebha_pkg::ARB_OWN)
		else $error("withdrawn hold during finish not dropped");

	// hold period and regain steps
	a_want_refused: assert property (@(posedge clock) disable iff (!rstn) // RULE_07
		(state_ff == ebha_pkg::ARB_HELD && held_cnt_ff >= ebha_pkg::WANT_CUTOFF
		&& bus_want_back_n) |=> bus_want_back_n)
		else $error("bus want raised past cutoff");
	a_withdraw_regain: assert property (@(posedge clock) disable iff (!rstn) // RULE_06
		s_withdraw |=> state_ff == ebha_pkg::ARB_REGAIN)
		else $error("withdrawn hold did not start regain");
	a_want_drops: assert property (@(posedge clock) disable iff (!rstn) // RULE_10
		state_ff == ebha_pkg::ARB_REGAIN |=> bus_want_back_n)
		else $error("bus want kept after regain");
	a_no_cycle_held: assert property (@(posedge clock) disable iff (!rstn) // RULE_09
		!bus_grant_ack_n |-> !cycle_allowed)
		else $error("own cycle allowed while granted");

	// drivers on while owning the bus
	a_drive_own: assert property (@(posedge clock) disable iff (!rstn) // RULE_11
		state_ff == ebha_pkg::ARB_OWN |-> (addr_oe == '1 && chip_select_line_oe == '1))
		else $error("bus not driven while owned");
endmodule // ebha_arbiter

// ===== verification/ebha_master_model.sv
`timescale 1ns/1ps
// ****************************************
// external bus master model
// ****************************************
module ebha_master_model
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rstn,
	// bench command
	input  wire logic       go,
	input  wire logic [7:0] keep_len,
	// arbitration pins
	input  wire logic       bus_grant_ack_n,
	output logic            hold_req_n
);
	logic [7:0] kept_ff;
	// take the bus on command, give it back after keep_len granted cycles
	always @(posedge clock)
	begin
		if (!rstn || hold_req_n)
			kept_ff <= 8'h00;
		else if (!bus_grant_ack_n)
			kept_ff <= kept_ff + 8'h01;
		if (!rstn)
			hold_req_n <= 1'h1;
		else if (go)
			hold_req_n <= 1'h0;
		else if (!bus_grant_ack_n && kept_ff + 8'h01 == keep_len)
			hold_req_n <= 1'h1;
	end
endmodule // ebha_master_model

// ===== verification/ebha_tb_top.sv
`timescale 1ns/1ps
module ebha_tb_top;
	logic                        clock, rstn, go, cycle_busy, want_bus, cycle_allowed;
	logic                        hold_req_n, bus_grant_ack_n, bus_want_back_n;
	logic [7:0]                  keep_len;
	logic [ebha_pkg::ADDR_W-1:0] addr_in, addr_oe;
	logic [ebha_pkg::DATA_W-1:0] data_in, data_oe;
	logic [ebha_pkg::CMD_W-1:0]  cmd_in, cmd_oe;
	logic [ebha_pkg::CS_W-1:0]   cs_in, chip_select_line_oe, chip_select_line_o, cs_pin;
	int                          n_errors = 0, n_compared = 0, n, w;
	// chip select pins with pull-up when released
	assign cs_pin = (chip_select_line_o & chip_select_line_oe) | ~chip_select_line_oe;
	ebha_arbiter u_dut (.clock(clock), .rstn(rstn), .hold_req_n(hold_req_n),
		.bus_grant_ack_n(bus_grant_ack_n), .bus_want_back_n(bus_want_back_n),
		.cycle_busy(cycle_busy), .want_bus(want_bus), .cycle_allowed(cycle_allowed),
		.addr_in(addr_in), .data_in(data_in), .cmd_in(cmd_in), .cs_in(cs_in),
		.addr_oe(addr_oe), .data_oe(data_oe), .cmd_oe(cmd_oe),
		.chip_select_line_oe(chip_select_line_oe), .chip_select_line_o(chip_select_line_o));
	ebha_master_model u_master (.clock(clock), .rstn(rstn), .go(go), .keep_len(keep_len),
		.bus_grant_ack_n(bus_grant_ack_n), .hold_req_n(hold_req_n));
	// ****************************************
	// checking and sequences
	// ****************************************
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// a request back counts only up to the cut-off after acknowledge
	function automatic logic want_taken(input int k);
		return k <= int'(ebha_pkg::WANT_CUTOFF);
	endfunction
	// one hold period: optional busy cycle, optional request back, release
	task automatic hold_cycle(input int busy_len, input int want_at, input int len);
		cycle_busy = busy_len > 0;
		want_bus = want_at == 0;
		keep_len = len[7:0];
		addr_in = $urandom;
		data_in = $urandom;
		cmd_in = $urandom;
		cs_in = $urandom;
		go = 1'h1;
		@(posedge clock); #1;
		go = 1'h0;
		check("allowed in hold", 1'h0, cycle_allowed);
		n = 0;
		while (bus_grant_ack_n !== 1'h0 && n < 40)
		begin
			check("early want", 1'h1, bus_want_back_n);
			check("drive in cycle", 1'h1, &{addr_oe, data_oe, cmd_oe});
			@(posedge clock); #1;
			n++;
			if (n == busy_len) cycle_busy = 1'h0;
		end
		check("ack delay", busy_len + 2, n);
		for (int i = 1; i < 60 && hold_req_n === 1'h0; i++)
		begin
			check("ack held", 1'h0, bus_grant_ack_n);
			check("cs released", 1'h1, &cs_pin);
			check("bus released", 1'h0, |{addr_oe, data_oe, cmd_oe});
			if (i == want_at) want_bus = 1'h1;
			@(posedge clock); #1;
		end
		check("want back", !want_taken(want_at), bus_want_back_n);
		@(posedge clock); #1;
		check("ack off", 1'h1, bus_grant_ack_n);
		check("still released", 1'h0, |addr_oe);
		@(posedge clock); #1;
		check("want off", 1'h1, bus_want_back_n);
		check("redrive", 1'h1, &{addr_oe, data_oe, cmd_oe, chip_select_line_oe});
		check("allowed", 1'h1, cycle_allowed);
		check("cs value", cs_in, cs_pin);
		want_bus = 1'h0;
	endtask
	// bus clock
	initial
	begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end
	// watchdog
	initial
	begin
		#1000000;
		n_errors++;
		end_of_test();
	end
	// main sequence
	initial
	begin
		{rstn, go, cycle_busy, want_bus, keep_len} = '0;
		{addr_in, data_in, cmd_in, cs_in} = '0;
		n = $urandom(32'h32aa);
		repeat (16) @(posedge clock);
		#1 rstn = 1'h1;
		check("ack reset", 1'h1, bus_grant_ack_n);
		check("want reset", 1'h1, bus_want_back_n);
		hold_cycle(0, 99, 3);
		hold_cycle(0, 0, 4);
		hold_cycle(3, 1, 5);
		hold_cycle(1, 2, 4);
		hold_cycle(0, 3, 6);
		repeat (40)
		begin
			w = $urandom % 5;
			hold_cycle($urandom % 4, w, w + 3 + $urandom % 5);
		end
		end_of_test();
	end
endmodule // ebha_tb_top
